// [core/lbpg_pkg.sv]
// Purpose: Shared constants for the local bus pin glue block
// Assumes: 20 MHz core clock, APB register access with 32-bit data
// Notes:   Offsets are byte addresses on the APB side
package lbpg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SK_PERIOD_NS = 4000;
  // Half period of the shift clock, longest time rounds down
  localparam int unsigned SK_HALF_CYC = SK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [6:0] SK_HALF_LAST = 7'(SK_HALF_CYC - 1);
  localparam int unsigned LED_STRETCH_US = 20000;
  localparam int unsigned LED_STRETCH_CYC =
    (LED_STRETCH_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BASE = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_SHIFT = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_IRQSEL_LSB = 0;
  localparam int unsigned CTRL_OVR_EN_BIT = 2;
  localparam int unsigned CTRL_OVR_VAL_BIT = 3;
  localparam int unsigned CTRL_CS_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [11:0] BASE_RST = 12'h030;
  localparam int unsigned SHIFT_CNT_LSB = 16;
  localparam int unsigned SHIFT_BUSY_BIT = 31;
  localparam int unsigned STAT_EXT_BIT = 3;
  localparam int unsigned STAT_WIDE_BIT = 4;
  localparam int unsigned STAT_BUSY_BIT = 5;
  localparam int unsigned STAT_ROM_BIT = 6;

  // ----------------------------------------------------------------
  // Shift engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW  = 2'b01,
    SH_HIGH = 2'b10
  } lbpg_shift_st_t;

endpackage

// [core/lbpg_stretch.sv]
// Purpose: Retriggerable pulse stretcher
// Assumes: Trigger is synchronous to clk_i
// Notes:   Active while the counter is non-zero
`timescale 1ns/1ps
module lbpg_stretch #(
  parameter int unsigned LEN = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trig_i,
  output logic active_o
);

  localparam int unsigned W = $clog2(LEN + 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Every trigger reloads, so a burst keeps the output on
  always_comb begin
    if (trig_i) begin
      cnt_nxt = W'(LEN);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign active_o = (cnt_r != '0);

endmodule // lbpg_stretch

// [core/lbpg_top.sv]
// Purpose: Local host bus pin glue: strobes, I/O ack, IRQ line select,
//          serial config memory pins, switches, LEDs, codec pin reuse
// Assumes: Pins synchronous to core_clk_i, APB from the core side
// Notes:   Two-way and open-drain pins split into out and enable
//
// What this block does
// - Drive exactly one of four IRQ outputs, chosen by line select.
// - In 16-bit mode pull I/O ack low on matching A4-A15, AEN low.
// - Generate a 4 us period shift clock for the config memory.
// - Drive config memory chip select and serial data out.
// - Sample config memory serial input when reading bits back.
// - Switch inputs pick a stored configuration, readable by software.
// - Internal codec: board LED lights on decoded access, stretched.
// - Internal codec: open-drain transmit, receive, link LEDs.
// - External codec: TX and link pins become TX enable and data.
// - External codec: board and RX LED pins become RXD and RX clock.
// - Codec strap low selects external codec, high selects internal.
// - Bus-width strap low gives 16-bit bus, open gives 8-bit.
// - Decode host addresses only while address enable is low.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module lbpg_top
  import lbpg_pkg::*;
#(
  parameter int unsigned LED_CYC = LED_STRETCH_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic aen_i,
  input wire logic [15:0] host_addr_i,
  input wire logic io_read_strobe_n_i,
  input wire logic io_write_strobe_n_i,
  input wire logic rom_read_strobe_n_i,
  output logic io_read_hit_o,
  output logic io_write_hit_o,
  input wire logic irq_req_i,
  output logic [3:0] irq_out_line_o,
  output logic [3:0] irq_out_line_oe_o,
  output logic wide_io_ack_n_o,
  output logic wide_io_ack_n_oe_o,
  output logic cfg_mem_shift_clock_o,
  output logic cfg_mem_select_o,
  output logic cfg_mem_serial_out_o,
  input wire logic cfg_mem_serial_in_i,
  input wire logic [1:0] cfg_switch_low_i,
  input wire logic cfg_switch_high_i,
  output logic [2:0] cfg_profile_o,
  input wire logic ext_codec_strap_n_i,
  input wire logic wide_bus_strap_n_i,
  output logic ext_codec_mode_o,
  output logic wide_bus_mode_o,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire logic link_up_i,
  input wire logic ext_tx_enable_i,
  input wire logic ext_tx_data_i,
  output logic ext_rx_data_o,
  output logic ext_receive_clock_o,
  output logic tx_activity_led_n_o,
  output logic tx_activity_led_n_oe_o,
  output logic link_led_n_o,
  output logic link_led_n_oe_o,
  input wire logic board_select_led_n_i,
  output logic board_select_led_n_o,
  output logic board_select_led_n_oe_o,
  input wire logic rx_activity_led_n_i,
  output logic rx_activity_led_n_o,
  output logic rx_activity_led_n_oe_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [11:0] base_r, base_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr_commit, mapped, start_shift;
  logic [31:0] stat_word, shift_word;
  logic strap_done_r, ext_mode_r, strap16_r, wide_mode_r;
  logic addr_hit, acc_hit, bsel_on;
  lbpg_shift_st_t st_r, st_nxt;
  logic [6:0] half_r, half_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [15:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
  logic sk_r, sk_nxt, dout_r, dout_nxt;
  logic [3:0] irq_r, irq_oe_r;
  logic ack_oe_r, rd_hit_r, wr_hit_r, rom_n_r;
  logic [2:0] prof_r;
  logic txp_r, txp_oe_r, lnk_r, lnk_oe_r;
  logic bsl_oe_r, rxl_oe_r, rxd_r, rxc_r, cs_r;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: pready rises one cycle into the access phase
  assign wr_commit = psel_i && penable_i && pready_r && pwrite_i;
  assign mapped = (paddr_i == OFS_CTRL) || (paddr_i == OFS_BASE) ||
                  (paddr_i == OFS_STAT) || (paddr_i == OFS_SHIFT);
  assign start_shift = wr_commit && (paddr_i == OFS_SHIFT) &&
                       (st_r == SH_IDLE) &&
                       (pwdata_i[SHIFT_CNT_LSB +: 5] != 5'h00);

  assign stat_word = {25'h0, rom_n_r, (st_r != SH_IDLE), wide_mode_r,
                      ext_mode_r, prof_r};
  assign shift_word = {(st_r != SH_IDLE), 10'h0, bits_r, rx_sh_r};

  always_comb begin
    ctrl_nxt = ctrl_r;
    base_nxt = base_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = psel_i && penable_i && !pready_r;
    if (pready_nxt) begin
      pslverr_nxt = !mapped;
      unique case (paddr_i)
        OFS_CTRL: prdata_nxt = {27'h0, ctrl_r};
        OFS_BASE: prdata_nxt = {16'h0, base_r, 4'h0};
        OFS_STAT: prdata_nxt = stat_word;
        OFS_SHIFT: prdata_nxt = shift_word;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_commit && paddr_i == OFS_CTRL) begin
      ctrl_nxt = pwdata_i[4:0];
    end
    if (wr_commit && paddr_i == OFS_BASE) begin
      base_nxt = pwdata_i[15:4];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      base_r <= BASE_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      base_r <= base_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Straps, caught once after reset release
  // ----------------------------------------------------------------
  // Codec mode may not change mid-run, so straps are read only once
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      strap_done_r <= 1'b0;
      ext_mode_r <= 1'b0;
      strap16_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      ext_mode_r <= !ext_codec_strap_n_i;
      strap16_r <= !wide_bus_strap_n_i;
    end
  end

  // Software override wins over the width strap
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wide_mode_r <= 1'b0;
    end else if (ctrl_r[CTRL_OVR_EN_BIT]) begin
      wide_mode_r <= ctrl_r[CTRL_OVR_VAL_BIT];
    end else begin
      wide_mode_r <= strap16_r;
    end
  end

  // ----------------------------------------------------------------
  // Host address decode and strobes
  // ----------------------------------------------------------------
  assign addr_hit = !aen_i && (host_addr_i[15:4] == base_r);
  assign acc_hit = addr_hit &&
                   (!io_read_strobe_n_i || !io_write_strobe_n_i);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_oe_r <= 1'b0;
      rd_hit_r <= 1'b0;
      wr_hit_r <= 1'b0;
      rom_n_r <= 1'b1;
      prof_r <= 3'h0;
    end else begin
      ack_oe_r <= wide_mode_r && addr_hit;
      rd_hit_r <= addr_hit && !io_read_strobe_n_i;
      wr_hit_r <= addr_hit && !io_write_strobe_n_i;
      rom_n_r <= rom_read_strobe_n_i;
      prof_r <= {cfg_switch_high_i, cfg_switch_low_i};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line select
  // ----------------------------------------------------------------
  // Unselected lines float so several cards can share the bus
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_oe_r <= 4'h1;
      irq_r <= 4'h0;
    end else begin
      irq_oe_r <= 4'h1 << ctrl_r[CTRL_IRQSEL_LSB +: 2];
      irq_r <= {4{irq_req_i}};
    end
  end

  // ----------------------------------------------------------------
  // Serial config memory shift engine
  // ----------------------------------------------------------------
  // Data leaves MSB first; input is taken on each rising shift edge
  always_comb begin
    st_nxt = st_r;
    half_nxt = half_r + 7'd1;
    bits_nxt = bits_r;
    tx_sh_nxt = tx_sh_r;
    rx_sh_nxt = rx_sh_r;
    sk_nxt = sk_r;
    dout_nxt = dout_r;
    unique case (st_r)
      SH_IDLE: begin
        half_nxt = 7'd0;
        if (start_shift) begin
          st_nxt = SH_LOW;
          tx_sh_nxt = pwdata_i[15:0];
          bits_nxt = pwdata_i[SHIFT_CNT_LSB +: 5];
          dout_nxt = pwdata_i[15];
          rx_sh_nxt = 16'h0000;
        end
      end
      SH_LOW: begin
        if (half_r == SK_HALF_LAST) begin
          st_nxt = SH_HIGH;
          half_nxt = 7'd0;
          sk_nxt = 1'b1;
          rx_sh_nxt = {rx_sh_r[14:0], cfg_mem_serial_in_i};
        end
      end
      SH_HIGH: begin
        if (half_r == SK_HALF_LAST) begin
          half_nxt = 7'd0;
          sk_nxt = 1'b0;
          bits_nxt = bits_r - 5'd1;
          tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
          st_nxt = (bits_r == 5'd1) ? SH_IDLE : SH_LOW;
          if (bits_r != 5'd1) begin
            dout_nxt = tx_sh_r[14];
          end
        end
      end
      default: begin
        st_nxt = SH_IDLE;
        sk_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= SH_IDLE;
      half_r <= 7'd0;
      bits_r <= 5'd0;
      tx_sh_r <= 16'h0000;
      rx_sh_r <= 16'h0000;
      sk_r <= 1'b0;
      dout_r <= 1'b0;
      cs_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      half_r <= half_nxt;
      bits_r <= bits_nxt;
      tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      sk_r <= sk_nxt;
      dout_r <= dout_nxt;
      cs_r <= ctrl_r[CTRL_CS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Board select stretch and LED / codec pins
  // ----------------------------------------------------------------
  // Long stretch is a parameter so simulation can shorten it
  lbpg_stretch #(
    .LEN(LED_CYC)
  ) u_bsel_stretch (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .trig_i(acc_hit && !ext_mode_r),
    .active_o(bsel_on)
  );

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      txp_r <= 1'b0;
      txp_oe_r <= 1'b0;
      lnk_r <= 1'b0;
      lnk_oe_r <= 1'b0;
      bsl_oe_r <= 1'b0;
      rxl_oe_r <= 1'b0;
      rxd_r <= 1'b0;
      rxc_r <= 1'b0;
    end else if (ext_mode_r) begin
      txp_r <= !ext_tx_enable_i;
      txp_oe_r <= 1'b1;
      lnk_r <= ext_tx_data_i;
      lnk_oe_r <= 1'b1;
      bsl_oe_r <= 1'b0;
      rxl_oe_r <= 1'b0;
      rxd_r <= board_select_led_n_i;
      rxc_r <= rx_activity_led_n_i;
    end else begin
      txp_r <= 1'b0;
      txp_oe_r <= tx_active_i;
      lnk_r <= 1'b0;
      lnk_oe_r <= link_up_i;
      bsl_oe_r <= bsel_on;
      rxl_oe_r <= rx_active_i;
      rxd_r <= 1'b0;
      rxc_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign io_read_hit_o = rd_hit_r;
  assign io_write_hit_o = wr_hit_r;
  assign irq_out_line_o = irq_r;
  assign irq_out_line_oe_o = irq_oe_r;
  assign wide_io_ack_n_o = 1'b0;
  assign wide_io_ack_n_oe_o = ack_oe_r;
  assign cfg_mem_shift_clock_o = sk_r;
  assign cfg_mem_select_o = cs_r;
  assign cfg_mem_serial_out_o = dout_r;
  assign cfg_profile_o = prof_r;
  assign ext_codec_mode_o = ext_mode_r;
  assign wide_bus_mode_o = wide_mode_r;
  assign ext_rx_data_o = rxd_r;
  assign ext_receive_clock_o = rxc_r;
  assign tx_activity_led_n_o = txp_r;
  assign tx_activity_led_n_oe_o = txp_oe_r;
  assign link_led_n_o = lnk_r;
  assign link_led_n_oe_o = lnk_oe_r;
  assign board_select_led_n_o = 1'b0;
  assign board_select_led_n_oe_o = bsl_oe_r;
  assign rx_activity_led_n_o = 1'b0;
  assign rx_activity_led_n_oe_o = rxl_oe_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_irq_sel;
    !$past(rst_i) |->
      irq_out_line_oe_o == (4'h1 << $past(ctrl_r[1:0]));
  endproperty
  a_irq_sel: assert property (p_irq_sel)
    else $error("IRQ enable does not follow line select");

  property p_ack;
    (wide_mode_r && !aen_i && host_addr_i[15:4] == base_r) |=>
      wide_io_ack_n_oe_o && !wide_io_ack_n_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("Wide I/O ack not asserted on hit");

  property p_ack_narrow;
    !wide_mode_r |=> !wide_io_ack_n_oe_o;
  endproperty
  a_ack_narrow: assert property (p_ack_narrow)
    else $error("Wide I/O ack driven in 8-bit mode");

  property p_aen;
    aen_i |=> !io_read_hit_o && !io_write_hit_o && !wide_io_ack_n_oe_o;
  endproperty
  a_aen: assert property (p_aen)
    else $error("Decode active while address enable high");

  property p_sk_period;
    $rose(cfg_mem_shift_clock_o) |->
      ##39 cfg_mem_shift_clock_o ##1 !cfg_mem_shift_clock_o;
  endproperty
  a_sk_period: assert property (p_sk_period)
    else $error("Shift clock high phase not 40 cycles");

  property p_sample;
    $rose(cfg_mem_shift_clock_o) |->
      rx_sh_r[0] == $past(cfg_mem_serial_in_i);
  endproperty
  a_sample: assert property (p_sample)
    else $error("Serial input not sampled on rising shift edge");

  property p_bsel;
    (acc_hit && !ext_mode_r) |-> ##2 board_select_led_n_oe_o;
  endproperty
  a_bsel: assert property (p_bsel)
    else $error("Board select LED not lit after access");

  property p_ext_pins;
    ext_mode_r && $past(ext_mode_r) |->
      !board_select_led_n_oe_o && !rx_activity_led_n_oe_o &&
      tx_activity_led_n_oe_o && link_led_n_oe_o;
  endproperty
  a_ext_pins: assert property (p_ext_pins)
    else $error("Pin directions wrong in external codec mode");

  c_shift: cover property (start_shift ##1 st_r == SH_LOW);
  c_ack: cover property ($rose(wide_io_ack_n_oe_o));
  c_bsel: cover property ($rose(board_select_led_n_oe_o));
  c_ext: cover property (ext_mode_r && strap_done_r);

endmodule // lbpg_top

// [tb/lbpg_host_model.sv]
// Purpose: Host model driving local bus strobes, address and qualifier
// Assumes: One bus cycle at a time, started by a one-cycle go pulse
// Notes:   A released address bus toggles, so stale values never match
`timescale 1ns/1ps
module lbpg_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] kind_i,
  input wire logic aen_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] len_i,
  output logic aen_o,
  output logic [15:0] addr_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic rom_n_o,
  output logic busy_o
);
  logic [3:0] cnt_r = 4'h0;
  initial begin
    aen_o = 1'h1;
    addr_o = 16'h5A5A;
    rd_n_o = 1'h1;
    wr_n_o = 1'h1;
    rom_n_o = 1'h1;
  end
  assign busy_o = (cnt_r != 4'h0);
  // Strobe stands len cycles, address and qualifier with it
  always @(posedge clk_i) begin
    if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        rd_n_o <= 1'h1;
        wr_n_o <= 1'h1;
        rom_n_o <= 1'h1;
        aen_o <= 1'h1;
        addr_o <= ~addr_o;
      end
    end else if (go_i) begin
      aen_o <= aen_i;
      addr_o <= addr_i;
      rd_n_o <= (kind_i != 2'h0);
      wr_n_o <= (kind_i != 2'h1);
      rom_n_o <= (kind_i != 2'h2);
      cnt_r <= len_i;
    end else begin
      addr_o <= ~addr_o;
    end
  end
endmodule // lbpg_host_model

// [tb/lbpg_top_tb.sv]
// Purpose: Self-checking bench for the local bus pin glue
// Assumes: APB from the core side, host model on the pins
// Notes:   APB results go through a queue checked by a monitor
`timescale 1ns/1ps
module lbpg_top_tb;
  import lbpg_pkg::*;
  localparam int unsigned LED_N = 8;
  logic core_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, prdy, perr;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd;
  logic go = 1'h0, haen = 1'h1, aen, rdn, wrn, romn, hbusy;
  logic [1:0] kind = 2'h0;
  logic [3:0] hlen = 4'h4;
  logic [15:0] hadr = 16'h0, addr;
  logic irq_req = 1'h0, ack_o, ack_oe, sk, cs, dout, din = 1'h0;
  logic [3:0] irq_o, irq_oe;
  logic [1:0] swl = 2'h0;
  logic swh = 1'h0, xstrap = 1'h1, wstrap = 1'h1, xmode, wmode;
  logic [2:0] prof;
  logic txa = 1'h0, rxa = 1'h0, lnk = 1'h0, xten = 1'h0, xtd = 1'h0;
  logic rxd = 1'h1, rclk = 1'h1, xrd, xrc, rdhit, wrhit;
  logic txo, txoe, lko, lkoe, bso, bsoe, rxo, rxoe;
  logic [33:0] ex;
  logic [33:0] expq[$];
  wire bs_pin = bsoe ? bso : rxd;
  wire rx_pin = rxoe ? rxo : rclk;
  int seed = 41, fail_count = 0, checked = 0, cyc = 0;
  time t0;

  always #25 core_clk_i = ~core_clk_i;

  lbpg_top #(.LED_CYC(LED_N)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .aen_i(aen),
    .host_addr_i(addr), .io_read_strobe_n_i(rdn),
    .io_write_strobe_n_i(wrn), .rom_read_strobe_n_i(romn),
    .io_read_hit_o(rdhit), .io_write_hit_o(wrhit), .irq_req_i(irq_req),
    .irq_out_line_o(irq_o), .irq_out_line_oe_o(irq_oe),
    .wide_io_ack_n_o(ack_o), .wide_io_ack_n_oe_o(ack_oe),
    .cfg_mem_shift_clock_o(sk), .cfg_mem_select_o(cs),
    .cfg_mem_serial_out_o(dout), .cfg_mem_serial_in_i(din),
    .cfg_switch_low_i(swl), .cfg_switch_high_i(swh),
    .cfg_profile_o(prof), .ext_codec_strap_n_i(xstrap),
    .wide_bus_strap_n_i(wstrap), .ext_codec_mode_o(xmode),
    .wide_bus_mode_o(wmode), .tx_active_i(txa), .rx_active_i(rxa),
    .link_up_i(lnk), .ext_tx_enable_i(xten), .ext_tx_data_i(xtd),
    .ext_rx_data_o(xrd), .ext_receive_clock_o(xrc),
    .tx_activity_led_n_o(txo), .tx_activity_led_n_oe_o(txoe),
    .link_led_n_o(lko), .link_led_n_oe_o(lkoe),
    .board_select_led_n_i(bs_pin), .board_select_led_n_o(bso),
    .board_select_led_n_oe_o(bsoe), .rx_activity_led_n_i(rx_pin),
    .rx_activity_led_n_o(rxo), .rx_activity_led_n_oe_o(rxoe));

  lbpg_host_model i_host (
    .clk_i(core_clk_i), .go_i(go), .kind_i(kind), .aen_i(haen),
    .addr_i(hadr), .len_i(hlen), .aen_o(aen), .addr_o(addr),
    .rd_n_o(rdn), .wr_n_o(wrn), .rom_n_o(romn), .busy_o(hbusy));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Read: d is the expected data; request held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    expq.push_back({~w, e, d});
    @(posedge core_clk_i);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    pa <= a;
    pwd <= w ? d : $random(seed);
    @(posedge core_clk_i);
    pen <= 1'h1;
    do @(posedge core_clk_i); while (prdy !== 1'h1);
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  // One host cycle, after the previous one has ended
  task automatic host(input logic [1:0] k, input logic a,
                      input logic [15:0] ad);
    while (hbusy === 1'h1) @(posedge core_clk_i);
    @(posedge core_clk_i);
    go <= 1'h1;
    kind <= k;
    haen <= a;
    hadr <= ad;
    @(posedge core_clk_i);
    go <= 1'h0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    rst_i <= 1'h1;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'h0;
    tick(6);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // APB monitor: oldest note against each answer
  always @(posedge core_clk_i) begin
    if (prdy === 1'h1) begin
      if (expq.size() == 0) begin
        chk("apb_extra", 32'h0, 32'h1);
      end else begin
        ex = expq.pop_front();
        chk("pslverr", 32'(ex[32]), 32'(perr));
        if (ex[33]) chk("prdata", ex[31:0], prd);
      end
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {swh, swl} = 3'($random(seed));
    do_reset();
    chk("irq_oe_rst", 32'h1, 32'(irq_oe));
    chk("profile", 32'({swh, swl}), 32'(prof));
    chk("modes", 32'h0, 32'({xmode, wmode}));
    apb(1'h0, OFS_CTRL, 32'h0, 1'h0);
    apb(1'h0, OFS_BASE, 32'h300, 1'h0);
    apb(1'h0, 8'h10, 32'h0, 1'h1);
    for (int s = 0; s < 4; s++) begin
      irq_req <= 1'($random(seed));
      apb(1'h1, OFS_CTRL, 32'(s), 1'h0);
      tick(2);
      chk("irq_oe", 32'(4'h1 << s), 32'(irq_oe));
      chk("irq_lvl", 32'(irq_req), 32'(irq_o[s]));
    end
    // Narrow bus decodes but never acknowledges wide
    host(2'h0, 1'h0, 16'h0307);
    tick(1);
    chk("hit8", 32'h2, 32'({rdhit, ack_oe}));
    apb(1'h1, OFS_CTRL, 32'hC, 1'h0);
    host(2'h1, 1'h0, 16'h030A);
    tick(1);
    chk("wr_ack", 32'h6, 32'({wrhit, ack_oe, ack_o}));
    host(2'h0, 1'h1, 16'h0300);
    tick(1);
    chk("aen_hi", 32'h0, 32'({rdhit, wrhit, ack_oe}));
    host(2'h0, 1'h0, 16'h0310);
    tick(1);
    chk("miss", 32'h0, 32'({rdhit, ack_oe}));
    apb(1'h1, OFS_BASE, 32'hABC0, 1'h0);
    host(2'h0, 1'h0, 16'hABCF);
    tick(1);
    chk("base_new", 32'h3, 32'({rdhit, ack_oe}));
    hlen <= 4'hF;
    host(2'h2, 1'h1, 16'h0000);
    apb(1'h0, OFS_STAT, 32'({4'h2, swh, swl}), 1'h0);
    hlen <= 4'h4;
    // Board LED stretch and retrigger
    tick(LED_N + 20);
    chk("bsel_off", 32'h0, 32'(bsoe));
    host(2'h0, 1'h0, 16'hABC1);
    tick(2);
    chk("bsel_on", 32'h2, 32'({bsoe, bso}));
    host(2'h1, 1'h0, 16'hABC2);
    tick(10);
    chk("bsel_retrig", 32'h1, 32'(bsoe));
    tick(LED_N + 4);
    chk("bsel_end", 32'h0, 32'(bsoe));
    for (int i = 0; i < 4; i++) begin
      {txa, rxa, lnk} <= 3'($random(seed));
      tick(2);
      chk("led_oe", 32'({txa, rxa, lnk}), 32'({txoe, rxoe, lkoe}));
      chk("led_o", 32'h0, 32'({txo, rxo, lko}));
    end
    // Serial memory: select, four bits out and back
    apb(1'h1, OFS_CTRL, 32'h10, 1'h0);
    tick(2);
    chk("select", 32'h1, 32'(cs));
    apb(1'h1, OFS_SHIFT, 32'h0004B000, 1'h0);
    // Busy with four bits left; a second start is ignored
    apb(1'h0, OFS_SHIFT, 32'h8004_0000, 1'h0);
    apb(1'h1, OFS_SHIFT, 32'h0001_0000, 1'h0);
    for (int i = 0; i < 4; i++) begin
      din <= 1'(4'h6 >> (3 - i));
      @(posedge sk);
      chk("dout", 32'(4'hB >> (3 - i)) & 32'h1, 32'(dout));
      if (i > 0) chk("sk_per", 32'd4000, 32'($time - t0));
      t0 = $time;
      #1;
    end
    tick(50);
    din <= 1'h0;
    apb(1'h0, OFS_SHIFT, 32'h6, 1'h0);
    // External codec, wide bus from straps
    xstrap <= 1'h0;
    wstrap <= 1'h0;
    do_reset();
    chk("modes_x", 32'h3, 32'({xmode, wmode}));
    apb(1'h0, OFS_STAT, 32'({4'hB, swh, swl}), 1'h0);
    host(2'h0, 1'h0, 16'h0300);
    for (int i = 0; i < 4; i++) begin
      {xten, xtd, rxd, rclk} <= 4'($random(seed));
      tick(2);
      chk("x_tx", 32'({~xten, 1'h1, xtd, 1'h1}),
          32'({txo, txoe, lko, lkoe}));
      chk("x_rx", 32'({rxd, rclk, 2'h0}),
          32'({xrd, xrc, bsoe, rxoe}));
    end
    // Software override forces 8-bit mode over the wide strap
    apb(1'h1, OFS_CTRL, 32'h4, 1'h0);
    tick(2);
    chk("ovr8", 32'h0, 32'(wmode));
    final_report();
  end
endmodule // lbpg_top_tb
